// *** hw/cic_regs.svh ***
`ifndef CIC_REGS_SVH
`define CIC_REGS_SVH

// Word addresses on the register bus
`define CIC_ADDR_CTRL 4'h0
`define CIC_ADDR_INCFG 4'h1
`define CIC_ADDR_PRE_A 4'h2
`define CIC_ADDR_PRE_B 4'h3
`define CIC_ADDR_CNT_A 4'h4
`define CIC_ADDR_CNT_B 4'h5
`define CIC_ADDR_DISP 4'h6
`define CIC_ADDR_ZERO 4'h7
`define CIC_ADDR_SSOFS 4'h8
`define CIC_ADDR_MIN 4'h9
`define CIC_ADDR_MAX 4'hA
`define CIC_ADDR_STAT 4'hB

// Field positions
`define CIC_CTRL_MODE_LSB 0
`define CIC_CTRL_PSEL_LSB 4
`define CIC_IN1_CMD_LSB 0
`define CIC_IN1_TRG_LSB 4
`define CIC_IN2_CMD_LSB 8
`define CIC_IN2_TRG_LSB 12
`define CIC_IN3_CMD_LSB 16
`define CIC_IN3_TRG_LSB 20

// Reset values and fixed settings
`define CIC_CTRL_RST 32'h0000_0000
`define CIC_INCFG_RST 32'h0000_1010
`define CIC_IN3_CMD 4'h9
`define CIC_IN3_TRG 2'h1

// Timing
`define CIC_CLK_HZ 25000000
`define CIC_FACTORY_HOLD_MS 1000
`define CIC_FACTORY_HOLD_CYC ((`CIC_FACTORY_HOLD_MS) * (`CIC_CLK_HZ / 1000))

`endif

// *** hw/cic_pkg.sv ***
package cic_pkg;
  typedef enum logic [1:0] {CIC_TRIG_LOW, CIC_TRIG_HIGH, CIC_TRIG_RISE, CIC_TRIG_FALL} cic_trig_t;
  typedef enum logic [3:0] {
    CIC_CMD_NONE, CIC_CMD_SET, CIC_CMD_FREEZE, CIC_CMD_ZERO, CIC_CMD_SET_A,
    CIC_CMD_SET_B, CIC_CMD_LOCK_A, CIC_CMD_LOCK_B, CIC_CMD_CLR_MM, CIC_CMD_FACTORY
  } cic_cmd_t;
  typedef enum logic [1:0] {CIC_MODE_SSI, CIC_MODE_COUNTER, CIC_MODE_STARTSTOP} cic_mode_t;

  // Level settings are the two static ones
  function automatic logic cic_is_level(input cic_trig_t t);
    return (t == CIC_TRIG_LOW) || (t == CIC_TRIG_HIGH);
  endfunction : cic_is_level
endpackage : cic_pkg

// *** hw/cic_trig_if.sv ***
`timescale 1ns/1ps
interface cic_trig_if;
  import cic_pkg::*;
  cic_trig_t cfg;
  logic active;
  logic fire;
  logic held;
  modport det (input cfg, output active, fire, held);
  modport use_side (output cfg, input active, fire, held);
endinterface : cic_trig_if

// *** hw/cic_trig.sv ***
`timescale 1ns/1ps
`include "cic_regs.svh"
module cic_trig import cic_pkg::*; #(
  parameter int unsigned HOLD = `CIC_FACTORY_HOLD_CYC
) (
  input wire logic clk_i,  // System clock
  input wire logic srst_i, // Sync reset, high
  input wire logic pin_i,  // Raw control input
  cic_trig_if.det bus      // Trigger results
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic act;
    logic fire;
    logic held;
    logic [31:0] cnt;
  } cic_trig_state_t;

  cic_trig_state_t s, next_s;
  logic lvl_on;

  // Only s2 and its delayed copy prev feed detection; s1 is read by s2 alone
  always_comb begin
    next_s = s;
    next_s.s1 = pin_i;
    next_s.s2 = s.s1;
    next_s.prev = s.s2;
    lvl_on = (bus.cfg == CIC_TRIG_LOW) ? !s.s2 : s.s2;
    next_s.act = cic_is_level(bus.cfg) && lvl_on;
    case (bus.cfg)
      CIC_TRIG_RISE: next_s.fire = s.s2 && !s.prev;
      CIC_TRIG_FALL: next_s.fire = !s.s2 && s.prev;
      default: next_s.fire = next_s.act && !s.act;
    endcase
    // Hold timer restarts on any gap in the active level
    if (!next_s.act) begin
      next_s.cnt = '0;
    end else if (s.cnt < HOLD) begin
      next_s.cnt = s.cnt + 32'h0000_0001;
    end
    next_s.held = next_s.act && (next_s.cnt >= HOLD);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.active = s.act;
  assign bus.fire = s.fire;
  assign bus.held = s.held;

  chk_edge_rise: assert property (@(posedge clk_i) disable iff (srst_i)
    (bus.cfg == CIC_TRIG_RISE && $stable(bus.cfg) && s.s2 && !s.prev) |=> s.fire)
    else $error("rising edge not reported");
  chk_held_active: assert property (@(posedge clk_i) disable iff (srst_i)
    s.held |-> s.act && $past(s.act))
    else $error("hold flag without continuous level");
endmodule : cic_trig

// *** hw/cic_pinsel.sv ***
`timescale 1ns/1ps
module cic_pinsel (
  input wire logic [3:0] sel_i, // Top-pin function select
  input wire logic d25_i,       // Data bit 25
  input wire logic d24_i,       // Data bit 24
  input wire logic err_i,       // Error flag, high active
  input wire logic stab_i,      // Data-stable flag, high active
  output logic upper_o,         // Line of bit 25
  output logic lower_o          // Line of bit 24
);
  // Invert a flag for its low-active form
  function automatic logic cic_pol(input logic v, input logic low);
    return low ? !v : v;
  endfunction : cic_pol

  // Unlisted codes fall back to plain data
  always_comb begin
    upper_o = d25_i;
    lower_o = d24_i;
    case (sel_i)
      4'h1: upper_o = err_i;
      4'h2: upper_o = cic_pol(err_i, 1'b1);
      4'h3: begin
        upper_o = err_i;
        lower_o = cic_pol(err_i, 1'b1);
      end
      4'h4, 4'h5: upper_o = cic_pol(stab_i, sel_i[0]);
      4'h6, 4'h7, 4'h8, 4'h9: begin
        upper_o = cic_pol(stab_i, sel_i == 4'h8 || sel_i == 4'h9);
        lower_o = cic_pol(err_i, sel_i == 4'h7 || sel_i == 4'h9);
      end
      4'hA: begin
        upper_o = stab_i;
        lower_o = cic_pol(stab_i, 1'b1);
      end
      default: begin
        upper_o = d25_i;
        lower_o = d24_i;
      end
    endcase
  end
endmodule : cic_pinsel

// *** hw/cic_top.sv ***
`timescale 1ns/1ps
`include "cic_regs.svh"
module cic_top import cic_pkg::*; #(
  parameter int unsigned HOLD_CYCLES = `CIC_FACTORY_HOLD_CYC
) (
  input wire logic clk_i,                  // System clock, 25 MHz
  input wire logic srst_i,                 // Sync reset, high
  input wire logic [3:0] avs_address_i,    // Word address
  input wire logic avs_read_i,             // Read request
  input wire logic avs_write_i,            // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  output logic [31:0] avs_readdata_o,      // Read data
  output logic avs_waitrequest_o,          // Stall
  input wire logic [2:0] ctrl_in_i,        // Control input pins
  input wire logic [31:0] pos_i,           // Current position, signed
  input wire logic cnt_a_inc_i,            // Count pulse channel A
  input wire logic cnt_b_inc_i,            // Count pulse channel B
  input wire logic error_i,                // Error flag
  input wire logic data_stable_i,          // Data-stable flag
  output logic [24:0] par_o,               // Parallel output, bit 1 at 0
  output logic factory_restore_o,          // Factory restore pulse
  output logic nv_store_o                  // Store offset pulse
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [1:0] mode;
    logic [3:0] psel;
    logic [3:0] cmd1;
    logic [1:0] trg1;
    logic [3:0] cmd2;
    logic [1:0] trg2;
    logic [31:0] pre_a;
    logic [31:0] pre_b;
    logic [31:0] cnt_a;
    logic [31:0] cnt_b;
    logic [31:0] disp;
    logic [31:0] zero;
    logic [31:0] ss_ofs;
    logic [31:0] vmin;
    logic [31:0] vmax;
    logic [24:0] par;
    logic fac_seen;
    logic fac;
    logic nv;
  } cic_top_state_t;

  cic_top_state_t s, next_s;
  // Nets, since each detector drives its own bit
  wire logic [2:0] act, fire, held;
  cic_cmd_t cmd [3];
  cic_trig_t trg [3];
  logic frz, lock_a, lock_b, load_a, load_b, clr_mm, fac_req;
  logic cap_disp, cap_zero, cap_ss;
  logic [31:0] val;
  logic up_line, low_line;
  logic req;

  // Input three ignores configuration entirely
  assign cmd[0] = cic_cmd_t'(s.cmd1);
  assign trg[0] = cic_trig_t'(s.trg1);
  assign cmd[1] = cic_cmd_t'(s.cmd2);
  assign trg[1] = cic_trig_t'(s.trg2);
  assign cmd[2] = cic_cmd_t'(`CIC_IN3_CMD);
  assign trg[2] = cic_trig_t'(`CIC_IN3_TRG);

  // One detector per control input
  for (genvar g = 0; g < 3; g++) begin : g_in
    cic_trig_if tif ();
    assign tif.cfg = trg[g];
    assign act[g] = tif.active;
    assign fire[g] = tif.fire;
    assign held[g] = tif.held;
    cic_trig #(
      .HOLD(HOLD_CYCLES)
    ) u_trig (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .pin_i(ctrl_in_i[g]),
      .bus(tif.det)
    );
  end

  // Command decode; static commands need a level setting
  always_comb begin
    frz = 1'b0;
    lock_a = 1'b0;
    lock_b = 1'b0;
    load_a = 1'b0;
    load_b = 1'b0;
    clr_mm = 1'b0;
    fac_req = 1'b0;
    cap_disp = 1'b0;
    cap_zero = 1'b0;
    cap_ss = 1'b0;
    for (int g = 0; g < 3; g++) begin
      case (cmd[g])
        CIC_CMD_SET: begin
          if (fire[g]) begin
            cap_disp = cap_disp || (s.mode == CIC_MODE_SSI);
            load_a = load_a || (s.mode == CIC_MODE_COUNTER);
            load_b = load_b || (s.mode == CIC_MODE_COUNTER);
            cap_ss = cap_ss || (s.mode == CIC_MODE_STARTSTOP);
          end
        end
        CIC_CMD_FREEZE: frz = frz || act[g];
        CIC_CMD_ZERO: cap_zero = cap_zero || (fire[g] && s.mode == CIC_MODE_SSI);
        CIC_CMD_SET_A: load_a = load_a || (fire[g] && s.mode == CIC_MODE_COUNTER);
        CIC_CMD_SET_B: load_b = load_b || (fire[g] && s.mode == CIC_MODE_COUNTER);
        CIC_CMD_LOCK_A: lock_a = lock_a || (act[g] && s.mode == CIC_MODE_COUNTER);
        CIC_CMD_LOCK_B: lock_b = lock_b || (act[g] && s.mode == CIC_MODE_COUNTER);
        CIC_CMD_CLR_MM: clr_mm = clr_mm || fire[g];
        CIC_CMD_FACTORY: fac_req = fac_req || held[g];
        default: ;
      endcase
    end
  end

  // Value shown on the parallel lines
  always_comb begin
    case (s.mode)
      CIC_MODE_COUNTER: val = s.cnt_a;
      CIC_MODE_STARTSTOP: val = pos_i + s.ss_ofs;
      default: val = pos_i - s.zero + s.disp;
    endcase
  end

  cic_pinsel u_pinsel (
    .sel_i(s.psel),
    .d25_i(val[24]),
    .d24_i(val[23]),
    .err_i(error_i),
    .stab_i(data_stable_i),
    .upper_o(up_line),
    .lower_o(low_line)
  );

  assign req = avs_read_i || avs_write_i;

  // Next state: bus first, then command effects win over bus writes
  always_comb begin
    next_s = s;
    next_s.ack = req && !s.ack;
    if (req && !s.ack) begin
      case (avs_address_i)
        `CIC_ADDR_CTRL: next_s.rdata = {24'h00_0000, s.psel, 2'h0, s.mode};
        `CIC_ADDR_INCFG: next_s.rdata = {10'h000, `CIC_IN3_TRG, `CIC_IN3_CMD,
                                         2'h0, s.trg2, s.cmd2, 2'h0, s.trg1, s.cmd1};
        `CIC_ADDR_PRE_A: next_s.rdata = s.pre_a;
        `CIC_ADDR_PRE_B: next_s.rdata = s.pre_b;
        `CIC_ADDR_CNT_A: next_s.rdata = s.cnt_a;
        `CIC_ADDR_CNT_B: next_s.rdata = s.cnt_b;
        `CIC_ADDR_DISP: next_s.rdata = s.disp;
        `CIC_ADDR_ZERO: next_s.rdata = s.zero;
        `CIC_ADDR_SSOFS: next_s.rdata = s.ss_ofs;
        `CIC_ADDR_MIN: next_s.rdata = s.vmin;
        `CIC_ADDR_MAX: next_s.rdata = s.vmax;
        `CIC_ADDR_STAT: next_s.rdata = {26'h000_0000, act, lock_b, lock_a, frz};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_i && s.ack) begin
      case (avs_address_i)
        `CIC_ADDR_CTRL: begin
          next_s.mode = avs_writedata_i[`CIC_CTRL_MODE_LSB +: 2];
          next_s.psel = avs_writedata_i[`CIC_CTRL_PSEL_LSB +: 4];
        end
        `CIC_ADDR_INCFG: begin
          next_s.cmd1 = avs_writedata_i[`CIC_IN1_CMD_LSB +: 4];
          next_s.trg1 = avs_writedata_i[`CIC_IN1_TRG_LSB +: 2];
          next_s.cmd2 = avs_writedata_i[`CIC_IN2_CMD_LSB +: 4];
          next_s.trg2 = avs_writedata_i[`CIC_IN2_TRG_LSB +: 2];
        end
        `CIC_ADDR_PRE_A: next_s.pre_a = avs_writedata_i;
        `CIC_ADDR_PRE_B: next_s.pre_b = avs_writedata_i;
        `CIC_ADDR_DISP: next_s.disp = avs_writedata_i;
        `CIC_ADDR_ZERO: next_s.zero = avs_writedata_i;
        `CIC_ADDR_SSOFS: next_s.ss_ofs = avs_writedata_i;
        default: ;
      endcase
    end
    // Counters: a preset beats a count pulse in the same cycle
    if (load_a) begin
      next_s.cnt_a = s.pre_a;
    end else if (cnt_a_inc_i && !lock_a) begin
      next_s.cnt_a = s.cnt_a + 32'h0000_0001;
    end
    if (load_b) begin
      next_s.cnt_b = s.pre_b;
    end else if (cnt_b_inc_i && !lock_b) begin
      next_s.cnt_b = s.cnt_b + 32'h0000_0001;
    end
    if (cap_disp) begin
      next_s.disp = pos_i - s.zero;
    end
    if (cap_zero) begin
      next_s.zero = pos_i;
    end
    if (cap_ss) begin
      next_s.ss_ofs = val;
    end
    next_s.nv = cap_ss;
    // Output and extremes hold still while frozen; a min/max clear still resets the extremes
    if (!frz) begin
      next_s.par = {up_line, low_line, val[22:0]};
      if ($signed(val) < $signed(s.vmin)) begin
        next_s.vmin = val;
      end
      if ($signed(val) > $signed(s.vmax)) begin
        next_s.vmax = val;
      end
    end
    if (clr_mm) begin
      next_s.vmin = val;
      next_s.vmax = val;
    end
    // One pulse per hold; restore also drops local settings
    next_s.fac_seen = fac_req;
    next_s.fac = fac_req && !s.fac_seen;
    if (fac_req && !s.fac_seen) begin
      next_s.mode = 2'(`CIC_CTRL_RST >> `CIC_CTRL_MODE_LSB);
      next_s.psel = 4'(`CIC_CTRL_RST >> `CIC_CTRL_PSEL_LSB);
      next_s.cmd1 = 4'(`CIC_INCFG_RST >> `CIC_IN1_CMD_LSB);
      next_s.trg1 = 2'(`CIC_INCFG_RST >> `CIC_IN1_TRG_LSB);
      next_s.cmd2 = 4'(`CIC_INCFG_RST >> `CIC_IN2_CMD_LSB);
      next_s.trg2 = 2'(`CIC_INCFG_RST >> `CIC_IN2_TRG_LSB);
      next_s.pre_a = 32'h0000_0000;
      next_s.pre_b = 32'h0000_0000;
      next_s.disp = 32'h0000_0000;
      next_s.zero = 32'h0000_0000;
      next_s.ss_ofs = 32'h0000_0000;
    end
  end

  // Reset values mirror the factory defaults
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
      s.trg1 <= 2'(`CIC_INCFG_RST >> `CIC_IN1_TRG_LSB);
      s.trg2 <= 2'(`CIC_INCFG_RST >> `CIC_IN2_TRG_LSB);
    end else begin
      s <= next_s;
    end
  end

  // Waitrequest drops one cycle after the request appears
  assign avs_waitrequest_o = req && !s.ack;
  assign avs_readdata_o = s.rdata;
  assign par_o = s.par;
  assign factory_restore_o = s.fac;
  assign nv_store_o = s.nv;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  chk_sel_data: assert property ((!frz && s.psel == 4'h0)
    |=> par_o[24] == $past(val[24]) && par_o[23] == $past(val[23]))
    else $error("select 0 data lines wrong");
  chk_sel_err_hi: assert property ((!frz && s.psel == 4'h1)
    |=> par_o[24] == $past(error_i) && par_o[23] == $past(val[23]))
    else $error("select 1 lines wrong");
  chk_sel_err_lo: assert property ((!frz && s.psel == 4'h2)
    |=> par_o[24] == !$past(error_i))
    else $error("select 2 error polarity wrong");
  chk_sel_err_pair: assert property ((!frz && s.psel == 4'h3)
    |=> par_o[24] == $past(error_i) && par_o[23] != par_o[24])
    else $error("select 3 pair wrong");
  chk_sel_stab_lo: assert property ((!frz && s.psel == 4'h5)
    |=> par_o[24] == !$past(data_stable_i))
    else $error("select 5 stable polarity wrong");
  chk_sel_mixed: assert property ((!frz && s.psel == 4'h7)
    |=> par_o[24] == $past(data_stable_i) && par_o[23] == !$past(error_i))
    else $error("select 7 lines wrong");
  chk_sel_stab_pair: assert property ((!frz && s.psel == 4'hA)
    |=> par_o[24] == $past(data_stable_i) && par_o[23] != par_o[24])
    else $error("select 10 pair wrong");
  chk_freeze_hold: assert property (frz |=> $stable(par_o))
    else $error("parallel output moved while frozen");
  chk_preset_both: assert property ((fire[0] && cmd[0] == CIC_CMD_SET
    && s.mode == CIC_MODE_COUNTER) |=> s.cnt_a == $past(s.pre_a) && s.cnt_b == $past(s.pre_b))
    else $error("counters not preset");
  chk_lock_a: assert property ((lock_a && !load_a) |=> s.cnt_a == $past(s.cnt_a))
    else $error("locked counter moved");
  chk_minmax_clr: assert property (clr_mm |=> s.vmin == s.vmax)
    else $error("min max not cleared");
  chk_factory_pulse: assert property (factory_restore_o |-> $past(held != 3'h0)
    && !$past(factory_restore_o))
    else $error("factory pulse without hold");
  chk_nv_store: assert property (cap_ss |=> nv_store_o && s.ss_ofs == $past(val))
    else $error("offset store missing");
  chk_zero_cap: assert property (cap_zero |=> s.zero == $past(pos_i))
    else $error("zero offset not captured");
  chk_bus_wait: assert property (req && !s.ack |=> !avs_waitrequest_o || !req)
    else $error("waitrequest held too long");

  cov_factory: cover property (factory_restore_o);
  cov_freeze: cover property (frz ##1 frz);
  cov_read: cover property (avs_read_i && !avs_waitrequest_o);
  cov_preset: cover property (load_a && load_b);
endmodule : cic_top

// *** tb/cic_sw_model.sv ***
`timescale 1ns/1ps
// Switches or PLC outputs on the three control inputs
module cic_sw_model (
  input wire logic clk_i,  // System clock, used only to pace changes
  output logic [2:0] pins_o // Control input levels, idle low
);
  initial pins_o = 3'h0;

  // Change one line just after a rising edge, like a slow contact
  task automatic set_pin(input int idx, input logic val);
    @(posedge clk_i);
    pins_o[idx] <= val;
  endtask : set_pin

  // Held active long enough for synchroniser and detector to see it
  task automatic hold(input int idx, input int n);
    set_pin(idx, 1'b1);
    repeat (n) @(posedge clk_i);
    set_pin(idx, 1'b0);
    repeat (8) @(posedge clk_i);
  endtask : hold

  // Short press: one rising and one falling edge
  task automatic pulse(input int idx);
    hold(idx, 8);
  endtask : pulse
endmodule : cic_sw_model

// *** tb/tb_cic_top.sv ***
`timescale 1ns/1ps
`include "cic_regs.svh"
`define TB_CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); fail_count++; end end
module tb_cic_top;
  import cic_pkg::*;
  localparam int HOLD = 20; // Short hold so the restore fits the run
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [2:0] pins;
  logic [31:0] pos_i;
  logic cnt_a_inc_i;
  logic cnt_b_inc_i;
  logic error_i;
  logic data_stable_i;
  logic [24:0] par_o;
  logic fac_o;
  logic nv_o;
  logic [31:0] rdata;
  int fac_n = 0;
  int nv_n = 0;
  int fail_count = 0;
  int comparisons = 0;

  // 25 MHz system clock
  always #20 clk_i = ~clk_i;

  cic_sw_model sw (.clk_i(clk_i), .pins_o(pins));

  cic_top #(.HOLD_CYCLES(HOLD)) dut (
    .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ctrl_in_i(pins), .pos_i(pos_i),
    .cnt_a_inc_i(cnt_a_inc_i), .cnt_b_inc_i(cnt_b_inc_i), .error_i(error_i),
    .data_stable_i(data_stable_i), .par_o(par_o), .factory_restore_o(fac_o),
    .nv_store_o(nv_o)
  );

  // Pulse counters; pulses are one cycle so each edge sees them once
  always @(posedge clk_i) begin
    if (fac_o === 1'b1) fac_n++;
    if (nv_o === 1'b1) nv_n++;
  end

  task automatic end_sim;
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // One bus cycle; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    // Only the watchdog ends a wait that never finishes
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0);
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    `TB_CHK("bus_answer", 2, n) // One wait state per request
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    `TB_CHK(nm, ex, rdata)
  endtask : rd_chk

  // Commands and triggers of inputs one and two
  task automatic cfg(input logic [3:0] c1, input logic [1:0] t1,
                     input logic [3:0] c2, input logic [1:0] t2);
    wr(`CIC_ADDR_INCFG, {18'h0, t2, c2, 2'h0, t1, c1});
  endtask : cfg

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_n

  task automatic count(input int n);
    repeat (n) begin
      @(posedge clk_i);
      cnt_a_inc_i <= 1'b1;
      cnt_b_inc_i <= 1'b1;
      @(posedge clk_i);
      cnt_a_inc_i <= 1'b0;
      cnt_b_inc_i <= 1'b0;
    end
  endtask : count

  function automatic logic [1:0] exp_aux(input int sel, input logic d25, input logic d24,
                                         input logic e, input logic s);
    case (sel)
      1: return {e, d24};
      2: return {~e, d24};
      3: return {e, ~e};
      4: return {s, d24};
      5: return {~s, d24};
      6: return {s, e};
      7: return {s, ~e};
      8: return {~s, e};
      9: return {~s, ~e};
      10: return {s, ~s};
      default: return {d25, d24};
    endcase
  endfunction : exp_aux

  // Reset values, fixed third input, unmapped and read-only places
  task automatic t_regs;
    rd_chk("ctrl", `CIC_ADDR_CTRL, 32'h0);
    rd_chk("incfg", `CIC_ADDR_INCFG, 32'h0019_1010);
    wr(4'hC, 32'hFFFF_FFFF);
    rd_chk("unmapped", 4'hC, 32'h0);
    wr(`CIC_ADDR_CNT_A, 32'h55);
    rd_chk("cnt_a_ro", `CIC_ADDR_CNT_A, 32'h0);
    wr(`CIC_ADDR_INCFG, 32'h0000_3737);
    rd_chk("incfg_wr", `CIC_ADDR_INCFG, 32'h0019_3737);
    cfg(4'h0, 2'h1, 4'h0, 2'h1);
  endtask : t_regs

  // Every top-pin select with all flag combinations; 11 acts as 0
  task automatic t_pinsel;
    pos_i <= 32'h0100_0000;
    for (int sel = 0; sel < 12; sel++) begin
      wr(`CIC_ADDR_CTRL, {24'h0, sel[3:0], 4'h0});
      for (int k = 0; k < 4; k++) begin
        error_i <= k[0];
        data_stable_i <= k[1];
        wait_n(4);
        `TB_CHK("aux_lines", exp_aux(sel, 1'b1, 1'b0, k[0], k[1]), par_o[24:23])
      end
    end
    error_i <= 1'b0;
    data_stable_i <= 1'b0;
    wr(`CIC_ADDR_CTRL, 32'h0);
  endtask : t_pinsel

  // Freeze holds output while level active; ignored on an edge trigger
  task automatic t_freeze;
    pos_i <= 32'h111;
    cfg(4'h2, 2'h1, 4'h0, 2'h1);
    wait_n(8);
    sw.set_pin(0, 1'b1);
    wait_n(8);
    pos_i <= 32'h222;
    wait_n(8);
    `TB_CHK("frozen", 23'h111, par_o[22:0])
    sw.set_pin(0, 1'b0);
    wait_n(8);
    `TB_CHK("thawed", 23'h222, par_o[22:0])
    cfg(4'h2, 2'h2, 4'h0, 2'h1);
    sw.set_pin(0, 1'b1);
    wait_n(8);
    pos_i <= 32'h333;
    wait_n(8);
    `TB_CHK("edge_freeze", 23'h333, par_o[22:0])
    sw.set_pin(0, 1'b0);
    wait_n(8);
  endtask : t_freeze

  task automatic t_minmax;
    cfg(4'h8, 2'h2, 4'h0, 2'h1);
    pos_i <= 32'd50;
    wait_n(4);
    pos_i <= 32'd20;
    wait_n(4);
    sw.pulse(0);
    pos_i <= 32'd30;
    wait_n(4);
    rd_chk("min", `CIC_ADDR_MIN, 32'd20);
    rd_chk("max", `CIC_ADDR_MAX, 32'd30);
  endtask : t_minmax

  // Zero capture on input one, display capture on input two
  task automatic t_capture;
    cfg(4'h3, 2'h2, 4'h1, 2'h3);
    pos_i <= 32'h123;
    wait_n(4);
    sw.pulse(0);
    rd_chk("zero", `CIC_ADDR_ZERO, 32'h123);
    `TB_CHK("zeroed", 23'h0, par_o[22:0])
    pos_i <= 32'h200;
    wait_n(4);
    sw.pulse(1);
    rd_chk("display", `CIC_ADDR_DISP, 32'hDD);
    `TB_CHK("shifted", 23'h1BA, par_o[22:0])
  endtask : t_capture

  task automatic t_counter;
    wr(`CIC_ADDR_CTRL, 32'h1);
    wr(`CIC_ADDR_PRE_A, 32'h5);
    wr(`CIC_ADDR_PRE_B, 32'h9);
    cfg(4'h4, 2'h2, 4'h5, 2'h2);
    sw.pulse(0);
    rd_chk("cnt_a", `CIC_ADDR_CNT_A, 32'h5);
    rd_chk("cnt_b", `CIC_ADDR_CNT_B, 32'h0);
    sw.pulse(1);
    rd_chk("cnt_b", `CIC_ADDR_CNT_B, 32'h9);
    // Lock A on a high level, B on a low level; each lock acts alone
    cfg(4'h6, 2'h1, 4'h7, 2'h0);
    sw.set_pin(0, 1'b1);
    sw.set_pin(1, 1'b1);
    wait_n(8);
    count(3);
    rd_chk("cnt_a_lock", `CIC_ADDR_CNT_A, 32'h5);
    rd_chk("cnt_b_free", `CIC_ADDR_CNT_B, 32'hC);
    sw.set_pin(0, 1'b0);
    sw.set_pin(1, 1'b0);
    wait_n(8);
    count(3);
    rd_chk("cnt_a_free", `CIC_ADDR_CNT_A, 32'h8);
    rd_chk("cnt_b_lock", `CIC_ADDR_CNT_B, 32'hC);
    rd_chk("stat_lock_b", `CIC_ADDR_STAT, 32'h14);
    `TB_CHK("par_count", 23'h8, par_o[22:0])
    cfg(4'h1, 2'h2, 4'h0, 2'h1);
    sw.pulse(0);
    rd_chk("cnt_a_set", `CIC_ADDR_CNT_A, 32'h5);
    rd_chk("cnt_b_set", `CIC_ADDR_CNT_B, 32'h9);
  endtask : t_counter

  task automatic t_startstop;
    int n0;
    n0 = nv_n;
    wr(`CIC_ADDR_CTRL, 32'h2);
    pos_i <= 32'h55;
    sw.pulse(0);
    `TB_CHK("nv_store", 1, nv_n - n0)
    rd_chk("ss_ofs", `CIC_ADDR_SSOFS, 32'h55);
    // Zero capture is refused outside its own mode
    cfg(4'h3, 2'h2, 4'h0, 2'h1);
    sw.pulse(0);
    rd_chk("zero_mode", `CIC_ADDR_ZERO, 32'h123);
  endtask : t_startstop

  // Restore needs a long level hold; edge-triggered restore is refused
  task automatic t_factory;
    cfg(4'h9, 2'h2, 4'h0, 2'h1);
    sw.hold(0, 40);
    `TB_CHK("fac_edge", 0, fac_n)
    sw.hold(2, 10);
    `TB_CHK("fac_short", 0, fac_n)
    sw.set_pin(2, 1'b1);
    wait_n(40);
    `TB_CHK("fac_long", 1, fac_n)
    wait_n(40);
    `TB_CHK("fac_once", 1, fac_n)
    sw.set_pin(2, 1'b0);
    wait_n(8);
    rd_chk("ctrl_rst", `CIC_ADDR_CTRL, 32'h0);
    rd_chk("incfg_rst", `CIC_ADDR_INCFG, 32'h0019_1010);
    rd_chk("pre_a_rst", `CIC_ADDR_PRE_A, 32'h0);
  endtask : t_factory

  initial begin
    // Quiet inputs while reset is held
    avs_address_i <= 4'h0;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    avs_writedata_i <= 32'h0;
    pos_i <= 32'h0;
    cnt_a_inc_i <= 1'b0;
    cnt_b_inc_i <= 1'b0;
    error_i <= 1'b0;
    data_stable_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    t_regs;
    t_pinsel;
    t_freeze;
    t_minmax;
    t_capture;
    t_counter;
    t_startstop;
    t_factory;
    end_sim;
  end

  // Whole run needs about 800 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    $display("ERROR watchdog expected done seen timeout");
    fail_count++;
    end_sim;
  end
endmodule : tb_cic_top
